// ==== rtl/prs_mem_port.sv ====
// Single-access memory port used for context block traffic.
// Assumes the memory holds valid until it returns a one-cycle ack.
`timescale 1ns/100ps
module prs_mem_port (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// Access request from the sequencer
	input  wire logic              i_start,
	input  wire logic              i_write,
	input  wire logic [63:0]       i_addr,
	input  wire logic [63:0]       i_wdata,
	// Memory side
	input  wire logic              i_mem_ack,
	input  wire logic [63:0]       i_mem_rdata,
	output prs_pkg::prs_mem_t      o_mem,
	// Completion
	output logic                   o_done,
	output logic [63:0]            o_rdata
);
	import prs_pkg::*;

	prs_mem_t    mem;
	prs_mem_t    next_mem;
	logic        done;
	logic        next_done;
	logic [63:0] rdata;
	logic [63:0] next_rdata;

	// Hold a request until ack, then report one done pulse
	always_comb begin
		next_mem   = mem;
		next_done  = 1'b0;
		next_rdata = rdata;
		if (mem.valid) begin
			if (i_mem_ack) begin
				next_mem.valid = 1'b0;
				next_done      = 1'b1;
				next_rdata     = i_mem_rdata;
			end
		end else if (i_start) begin
			next_mem.valid = 1'b1;
			next_mem.write = i_write;
			next_mem.addr  = i_addr;
			next_mem.wdata = i_wdata;
		end
	end

	// Register the port state
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mem   <= '0;
			done  <= 1'b0;
			rdata <= 64'h0;
		end else begin
			mem   <= next_mem;
			done  <= next_done;
			rdata <= next_rdata;
		end
	end

	assign o_mem   = mem;
	assign o_done  = done;
	assign o_rdata = rdata;

endmodule

// ==== rtl/prs_pkg.sv ====
// Package for the privileged register set: selectors, states, carriers,
// context block field offsets and identity limits.
// Assumes a 64-bit datapath and one clock domain.
package prs_pkg;

	// ----------------------------------------------------------------
	// Sizes and limits
	// ----------------------------------------------------------------
	localparam int          PRS_PAGE_BITS = 13;      // Page offset width
	localparam int          PRS_CPU_W     = 8;       // Processor number pins
	localparam logic [7:0]  PRS_CPU_COUNT = 8'h40;   // Configurable CPUs
	localparam logic [63:0] PRS_VIRTUAL_PAGE_TABLE_BASE_RST  = 64'h0;   // Before console load

	// Field offsets inside the process context block
	localparam logic [63:0] PRS_OFF_KSP = 64'h0;
	localparam logic [63:0] PRS_OFF_ESP = 64'h8;
	localparam logic [63:0] PRS_OFF_SSP = 64'h10;
	localparam logic [63:0] PRS_OFF_USP = 64'h18;

	// Processor modes, used as stack pointer index
	localparam logic [1:0] PRS_MODE_KERN  = 2'h0;
	localparam logic [1:0] PRS_MODE_EXEC  = 2'h1;
	localparam logic [1:0] PRS_MODE_SUPER = 2'h2;
	localparam logic [1:0] PRS_MODE_USER  = 2'h3;

	// ----------------------------------------------------------------
	// Register selectors for move-to / move-from
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PRS_SEL_FLUSH_NG    = 4'h0,
		PRS_SEL_FLUSH_BOTH  = 4'h1,
		PRS_SEL_FLUSH_DATA  = 4'h2,
		PRS_SEL_FLUSH_INSTR = 4'h3,
		PRS_SEL_EXEC_SP     = 4'h4,
		PRS_SEL_SUPER_SP    = 4'h5,
		PRS_SEL_USER_SP     = 4'h6,
		PRS_SEL_VIRTUAL_PAGE_TABLE_BASE        = 4'h7,
		PRS_SEL_IDENT       = 4'h8,
		PRS_SEL_CTX_SWAP    = 4'h9
	} prs_sel_t;

	// Main sequencer states, one-hot
	typedef enum logic [4:0] {
		S_BOOT = 5'h01,
		S_IDLE = 5'h02,
		S_INV  = 5'h04,
		S_MEM  = 5'h08,
		S_LOAD = 5'h10
	} prs_state_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		prs_sel_t    sel;
		logic [63:0] arg;
	} prs_req_t;

	typedef struct packed {
		logic        valid;
		logic        nonglobal;
		logic        data;
		logic        instr;
		logic [63:0] va;
	} prs_tlb_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [63:0] addr;
		logic [63:0] wdata;
	} prs_mem_t;

	// Context block offset of a mode's stack pointer
	function automatic logic [63:0] prs_off(input logic [1:0] mode);
		case (mode)
			PRS_MODE_KERN:  prs_off = PRS_OFF_KSP;
			PRS_MODE_EXEC:  prs_off = PRS_OFF_ESP;
			PRS_MODE_SUPER: prs_off = PRS_OFF_SSP;
			default:        prs_off = PRS_OFF_USP;
		endcase
	endfunction

endpackage

// ==== rtl/prs_top.sv ====
// Privileged register set: translation buffer invalidate commands, mode
// stack pointers, virtual page table base and processor identity.
// Assumes one move-to/move-from request at a time, a translation buffer
// that acks invalidates, and a memory that acks context block accesses.
//
// Summary of operation
// - Nonglobal flush invalidates entries whose global mapping bit is clear.
// - An implementation may flush more, even all; software tolerates it.
// - Combined single flush hits both data and instruction buffers.
// - Data flush hits only data buffer; instruction flush only instruction.
// - Single flush address comes from the argument; any in-page address works.
// - Single flush may hit more; a miss may or may not change state.
// - Mode stack pointers live internally or in the context block.
// - Stack pointers start from the initial context block at boot.
// - Current mode stack pointer is reachable as scalar register 30 when held internally.
// - Context swap loads stack pointers from the new context block.
// - Identity read returns processor number below the processor count.
// - The all-ones value is never returned as a processor number.
`timescale 1ns/100ps
module prs_top (
	// Clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_rst,
	// Privileged register request
	input  wire prs_pkg::prs_req_t         i_req,
	output logic                           o_busy,
	output logic                           o_done,
	output logic [63:0]                    o_result,
	// Configuration and context
	input  wire logic                      i_sp_internal,
	input  wire logic [63:0]               i_ctx_base,
	input  wire logic [prs_pkg::PRS_CPU_W-1:0] i_cpu_num,
	// Scalar register 30 path
	input  wire logic [1:0]                i_cur_mode,
	input  wire logic                      i_sp30_we,
	input  wire logic [63:0]               i_sp30_wdata,
	output logic [63:0]                    o_sp30,
	// Translation buffer
	output prs_pkg::prs_tlb_t              o_tlb,
	input  wire logic                      i_tlb_ack,
	output logic                           o_xlate_hold,
	// Context block memory
	output prs_pkg::prs_mem_t              o_mem,
	input  wire logic                      i_mem_ack,
	input  wire logic [63:0]               i_mem_rdata
);
	import prs_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	prs_state_t       state;
	prs_state_t       next_state;
	logic [63:0]      sp [4];
	logic [63:0]      next_sp [4];
	logic [63:0]      virtual_page_table_base;
	logic [63:0]      next_virtual_page_table_base;
	logic [63:0]      result;
	logic [63:0]      next_result;
	logic             done;
	logic             next_done;
	prs_tlb_t         tlb;
	prs_tlb_t         next_tlb;
	logic             issued;
	logic             next_issued;
	logic [1:0]       idx;
	logic [1:0]       next_idx;
	logic [1:0]       mode_q;
	logic [1:0]       next_mode;
	logic [63:0]      base;
	logic [63:0]      next_base;
	logic [63:0]      arg_q;
	logic [63:0]      next_arg;
	logic             wr;
	logic             next_wr;
	logic             boot;
	logic             next_boot;
	logic [PRS_CPU_W-1:0] cpu;
	logic [PRS_CPU_W-1:0] next_cpu;
	logic             busy;
	logic             next_busy;
	logic             hold;
	logic             next_hold;
	logic [63:0]      sp30;
	logic [63:0]      next_sp30;

	// Memory port handshake
	logic             mem_start;
	logic             mem_write;
	logic [63:0]      mem_addr;
	logic             mem_done;
	logic [63:0]      mem_rdata;

	// Request helpers
	logic             take;
	logic [1:0]       req_mode;
	logic [63:0]      page_va;

	assign take     = (state == S_IDLE) && i_req.valid;
	assign req_mode = 2'(i_req.sel - PRS_SEL_FLUSH_INSTR);
	// Page offset cleared so any address in the page selects it
	assign page_va  = {i_req.arg[63:PRS_PAGE_BITS],
		{PRS_PAGE_BITS{1'b0}}};

	// ----------------------------------------------------------------
	// Context block memory port
	// ----------------------------------------------------------------
	prs_mem_port u_mem (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_start     (mem_start),
		.i_write     (mem_write),
		.i_addr      (mem_addr),
		.i_wdata     (arg_q),
		.i_mem_ack   (i_mem_ack),
		.i_mem_rdata (i_mem_rdata),
		.o_mem       (o_mem),
		.o_done      (mem_done),
		.o_rdata     (mem_rdata)
	);

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state  = state;
		next_sp     = sp;
		next_virtual_page_table_base   = virtual_page_table_base;
		next_result = result;
		next_done   = 1'b0;
		next_tlb    = tlb;
		next_issued = issued;
		next_idx    = idx;
		next_mode   = mode_q;
		next_base   = base;
		next_arg    = arg_q;
		next_wr     = wr;
		next_boot   = boot;
		next_cpu    = cpu;
		mem_start   = 1'b0;
		mem_write   = 1'b0;
		mem_addr    = base + prs_off(idx);
		// Direct path to the current mode's pointer, lowest priority
		if (i_sp30_we) begin
			next_sp[i_cur_mode] = i_sp30_wdata;
		end
		case (state)
			S_BOOT: begin
				// Catch the processor number after reset release
				if (i_cpu_num >= PRS_CPU_COUNT) begin
					next_cpu = PRS_CPU_COUNT - 8'h01;
				end else begin
					next_cpu = i_cpu_num;
				end
				// Load pointers from the initial context block
				next_base   = i_ctx_base;
				next_idx    = PRS_MODE_KERN;
				next_boot   = 1'b1;
				next_issued = 1'b0;
				next_state  = i_sp_internal ? S_LOAD : S_IDLE;
			end
			S_IDLE: begin
				if (i_req.valid) begin
					next_wr     = i_req.write;
					next_arg    = i_req.arg;
					next_result = 64'h0;
					case (i_req.sel)
						PRS_SEL_FLUSH_NG: begin
							// Whole-buffer flush of nonglobal entries
							// A buffer that also flushes global ones is legal
							next_tlb   = '{1'b1, 1'b1, 1'b1, 1'b1, 64'h0};
							next_state = S_INV;
						end
						PRS_SEL_FLUSH_BOTH: begin
							// One page in both buffers
							next_tlb   = '{1'b1, 1'b0, 1'b1, 1'b1, page_va};
							next_state = S_INV;
						end
						PRS_SEL_FLUSH_DATA: begin
							// Data buffer only
							next_tlb   = '{1'b1, 1'b0, 1'b1, 1'b0, page_va};
							next_state = S_INV;
						end
						PRS_SEL_FLUSH_INSTR: begin
							// Instruction buffer only; a miss is harmless
							next_tlb   = '{1'b1, 1'b0, 1'b0, 1'b1, page_va};
							next_state = S_INV;
						end
						PRS_SEL_EXEC_SP, PRS_SEL_SUPER_SP, PRS_SEL_USER_SP: begin
							if (i_sp_internal) begin
								// Internal pointer registers
								if (i_req.write) begin
									next_sp[req_mode] = i_req.arg;
								end else begin
									next_result = sp[req_mode];
								end
								next_done = 1'b1;
							end else begin
								// Context block field in memory
								next_mode   = req_mode;
								next_base   = i_ctx_base;
								next_issued = 1'b0;
								next_state  = S_MEM;
							end
						end
						PRS_SEL_VIRTUAL_PAGE_TABLE_BASE: begin
							// Page table base read and write
							if (i_req.write) begin
								next_virtual_page_table_base = i_req.arg;
							end else begin
								next_result = virtual_page_table_base;
							end
							next_done = 1'b1;
						end
						PRS_SEL_IDENT: begin
							// Read only; zero-extended so never all ones
							if (!i_req.write) begin
								next_result = {{(64-PRS_CPU_W){1'b0}}, cpu};
							end
							next_done = 1'b1;
						end
						PRS_SEL_CTX_SWAP: begin
							// New process: pointers come from its block
							next_base   = i_req.arg;
							next_idx    = PRS_MODE_KERN;
							next_boot   = 1'b0;
							next_issued = 1'b0;
							if (i_sp_internal) begin
								next_state = S_LOAD;
							end else begin
								next_done = 1'b1;
							end
						end
						default: begin
							next_done = 1'b1;
						end
					endcase
				end
			end
			S_INV: begin
				// Stay busy until the buffer confirms the invalidate
				if (i_tlb_ack) begin
					next_tlb.valid = 1'b0;
					next_done      = 1'b1;
					next_state     = S_IDLE;
				end
			end
			S_MEM: begin
				// One context block access for an external pointer
				mem_addr  = base + prs_off(mode_q);
				mem_write = wr;
				if (!issued) begin
					mem_start   = 1'b1;
					next_issued = 1'b1;
				end else if (mem_done) begin
					if (!wr) begin
						next_result = mem_rdata;
					end
					next_done  = 1'b1;
					next_state = S_IDLE;
				end
			end
			S_LOAD: begin
				// Read all four pointers in mode order
				if (!issued) begin
					mem_start   = 1'b1;
					next_issued = 1'b1;
				end else if (mem_done) begin
					next_sp[idx] = mem_rdata;
					next_issued  = 1'b0;
					if (idx == PRS_MODE_USER) begin
						next_done  = !boot;
						next_boot  = 1'b0;
						next_state = S_IDLE;
					end else begin
						next_idx = idx + 2'h1;
					end
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		next_busy = (next_state != S_IDLE);
		next_hold = (next_state == S_INV) || (next_state == S_BOOT);
		next_sp30 = next_sp[i_cur_mode];
	end

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	// The page table base resets to zero, its value until loaded
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state  <= S_BOOT;
			sp     <= '{default: 64'h0};
			virtual_page_table_base   <= PRS_VIRTUAL_PAGE_TABLE_BASE_RST;
			result <= 64'h0;
			done   <= 1'b0;
			tlb    <= '0;
			issued <= 1'b0;
			idx    <= PRS_MODE_KERN;
			mode_q <= PRS_MODE_KERN;
			base   <= 64'h0;
			arg_q  <= 64'h0;
			wr     <= 1'b0;
			boot   <= 1'b1;
			cpu    <= '0;
			busy   <= 1'b1;
			hold   <= 1'b1;
			sp30   <= 64'h0;
		end else begin
			state  <= next_state;
			sp     <= next_sp;
			virtual_page_table_base   <= next_virtual_page_table_base;
			result <= next_result;
			done   <= next_done;
			tlb    <= next_tlb;
			issued <= next_issued;
			idx    <= next_idx;
			mode_q <= next_mode;
			base   <= next_base;
			arg_q  <= next_arg;
			wr     <= next_wr;
			boot   <= next_boot;
			cpu    <= next_cpu;
			busy   <= next_busy;
			hold   <= next_hold;
			sp30   <= next_sp30;
		end
	end

	// Outputs straight from flops
	assign o_busy       = busy;
	assign o_done       = done;
	assign o_result     = result;
	assign o_tlb        = tlb;
	assign o_xlate_hold = hold;
	assign o_sp30       = sp30;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence take_sel(prs_sel_t s, logic w);
		take && (i_req.sel == s) && (i_req.write == w);
	endsequence

	// Nonglobal flush reaches both buffers with the nonglobal flag
	ng_flush_a: assert property (
		take_sel(PRS_SEL_FLUSH_NG, 1'b1) |=>
		tlb.valid && tlb.nonglobal && tlb.data && tlb.instr)
		else $error("nonglobal flush not issued to both buffers");

	// Combined single flush targets both buffers
	both_flush_a: assert property (
		take_sel(PRS_SEL_FLUSH_BOTH, 1'b1) |=>
		tlb.valid && !tlb.nonglobal && tlb.data && tlb.instr)
		else $error("combined flush missed a buffer");

	// Data flush leaves the instruction buffer alone
	data_only_a: assert property (
		take_sel(PRS_SEL_FLUSH_DATA, 1'b1) |=>
		tlb.valid && tlb.data && !tlb.instr)
		else $error("data flush touched instruction buffer");

	// Instruction flush address is the argument page
	page_addr_a: assert property (
		take && (i_req.sel == PRS_SEL_FLUSH_INSTR) |=>
		tlb.va == {$past(i_req.arg[63:PRS_PAGE_BITS]),
		{PRS_PAGE_BITS{1'b0}}})
		else $error("flush address not the argument page");

	// Invalidate held and translation stalled until ack
	inv_hold_a: assert property (
		tlb.valid && !i_tlb_ack |=> tlb.valid && hold && !done)
		else $error("invalidate dropped before ack");

	// External pointer access reaches memory two cycles later
	ext_sp_a: assert property (
		take_sel(PRS_SEL_SUPER_SP, 1'b0) && !i_sp_internal |->
		##2 (o_mem.valid && !o_mem.write &&
		o_mem.addr == $past(i_ctx_base, 2) + PRS_OFF_SSP))
		else $error("external pointer read misaddressed");

	// Swap starts with the kernel field of the new block
	swap_load_a: assert property (
		take_sel(PRS_SEL_CTX_SWAP, 1'b1) && i_sp_internal |->
		##2 (o_mem.valid && o_mem.addr == $past(i_req.arg, 2) + PRS_OFF_KSP))
		else $error("swap did not fetch new context block");

	// Identity stays in range and is never all ones
	ident_a: assert property (
		take_sel(PRS_SEL_IDENT, 1'b0) |=>
		done && result < 64'(PRS_CPU_COUNT) && result != '1)
		else $error("processor identity out of range");

	// Page table base write then read returns the written value
	sequence virtual_page_table_base_wr_rd;
		take_sel(PRS_SEL_VIRTUAL_PAGE_TABLE_BASE, 1'b1) ##1 take_sel(PRS_SEL_VIRTUAL_PAGE_TABLE_BASE, 1'b0);
	endsequence
	virtual_page_table_base_rw_a: assert property (
		virtual_page_table_base_wr_rd |=> done && result == $past(i_req.arg, 2))
		else $error("page table base read mismatch");

endmodule

// ==== testbench/tb_prs_top.sv ====
// Self-checking bench for the privileged register set top level.
// Assumes prs_pkg and prs_top are compiled first; the bench plays the
// request source, the translation buffer and the context block memory.
`timescale 1ns/100ps
module tb_prs_top;
	import prs_pkg::*;

	// ----------------------------------------------------------------
	// Signals and bench state
	// ----------------------------------------------------------------
	logic              i_clk;
	logic              i_rst;
	prs_req_t          i_req;
	logic              o_busy;
	logic              o_done;
	logic [63:0]       o_result;
	logic              i_sp_internal;
	logic [63:0]       i_ctx_base;
	logic [7:0]        i_cpu_num;
	logic [1:0]        i_cur_mode;
	logic              i_sp30_we;
	logic [63:0]       i_sp30_wdata;
	logic [63:0]       o_sp30;
	prs_tlb_t          o_tlb;
	logic              i_tlb_ack;
	logic              o_xlate_hold;
	prs_mem_t          o_mem;
	logic              i_mem_ack;
	logic [63:0]       i_mem_rdata;
	logic [63:0]       exp_q [$];
	prs_tlb_t          tlb_q [$];
	logic [63:0]       mem [logic [63:0]];
	logic [63:0]       sp [3];
	logic [63:0]       v;
	logic [15:0]       lfsr = 16'hd073;
	int                errors = 0;
	int                n_compared = 0;
	int                mem_lat = 0;
	int                mem_wait = 0;
	int                tlb_lat = 0;
	int                tlb_wait = 0;

	prs_top dut (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_req        (i_req),
		.o_busy       (o_busy),
		.o_done       (o_done),
		.o_result     (o_result),
		.i_sp_internal(i_sp_internal),
		.i_ctx_base   (i_ctx_base),
		.i_cpu_num    (i_cpu_num),
		.i_cur_mode   (i_cur_mode),
		.i_sp30_we    (i_sp30_we),
		.i_sp30_wdata (i_sp30_wdata),
		.o_sp30       (o_sp30),
		.o_tlb        (o_tlb),
		.i_tlb_ack    (i_tlb_ack),
		.o_xlate_hold (o_xlate_hold),
		.o_mem        (o_mem),
		.i_mem_ack    (i_mem_ack),
		.i_mem_rdata  (i_mem_rdata)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Clock at 50 MHz
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	// Galois shift register step
	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		lfsr_step = {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
	endfunction

	// Four steps give one 64-bit random word
	function logic [63:0] rnd64();
		for (int k = 0; k < 4; k++) begin
			lfsr = lfsr_step(lfsr);
			rnd64 = {rnd64[47:0], lfsr};
		end
	endfunction

	// Unwritten memory words follow their address
	function automatic logic [63:0] memrd(input logic [63:0] a);
		memrd = mem.exists(a) ? mem[a] : a ^ 64'h0f0f_3c3c_a5a5_9696;
	endfunction

	// Inputs always move a fixed delay after the rising edge
	task automatic tick();
		@(posedge i_clk);
		#1;
	endtask

	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task print_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Reset for four cycles, then wait out the boot sequence
	task automatic do_reset(input logic internal, input logic [7:0] cpu);
		int n;
		i_rst = 1'b1;
		i_sp_internal = internal;
		i_cpu_num = cpu;
		repeat (4) tick();
		check(o_busy, 1'b1);
		i_rst = 1'b0;
		n = 0;
		while (o_busy !== 1'b0 && n < 100) begin
			tick();
			n++;
		end
		check(n == 100, 1'b0);
	endtask

	// One request held until taken; expected result noted first
	task automatic do_req(input logic wr, input prs_sel_t sel,
		input logic [63:0] arg, input logic [63:0] exp);
		int n;
		exp_q.push_back(exp);
		i_req = '{1'b1, wr, sel, arg};
		n = 0;
		while (o_busy !== 1'b0 && n < 200) begin
			tick();
			n++;
		end
		tick();
		i_req.valid = 1'b0;
		while (o_done !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
		check(n >= 200, 1'b0);
		tick();
	endtask

	// ----------------------------------------------------------------
	// Responders and result monitor
	// ----------------------------------------------------------------
	// Result monitor takes the oldest note on each completion
	always @(negedge i_clk) begin
		if (o_done === 1'b1) begin
			if (exp_q.size() == 0) check(1'b1, 1'b0);
			else check(o_result, exp_q.pop_front());
		end
	end

	// Context block memory, ack after mem_lat waiting cycles
	always @(posedge i_clk) begin
		#1;
		if (i_mem_ack) begin
			i_mem_ack = 1'b0;
			i_mem_rdata = ~i_mem_rdata;
		end else if (o_mem.valid === 1'b1) begin
			if (mem_wait < mem_lat) begin
				mem_wait++;
			end else begin
				mem_wait = 0;
				i_mem_ack = 1'b1;
				if (o_mem.write) mem[o_mem.addr] = o_mem.wdata;
				else i_mem_rdata = memrd(o_mem.addr);
			end
		end
	end

	// Translation buffer, checks each invalidate command it accepts
	always @(posedge i_clk) begin
		#1;
		if (i_tlb_ack) begin
			i_tlb_ack = 1'b0;
		end else if (o_tlb.valid === 1'b1) begin
			check(o_xlate_hold, 1'b1);
			if (tlb_wait < tlb_lat) begin
				tlb_wait++;
			end else begin
				tlb_wait = 0;
				i_tlb_ack = 1'b1;
				check(o_tlb, tlb_q.pop_front());
			end
		end
	end

	// Watchdog on the whole run
	initial begin
		#400000;
		errors++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		i_rst = 1'b1;
		i_req = '0;
		i_ctx_base = 64'h1000;
		i_cur_mode = 2'h2;
		i_sp30_we = 1'b0;
		i_sp30_wdata = 64'h0;
		i_tlb_ack = 1'b0;
		i_mem_ack = 1'b0;
		i_mem_rdata = 64'h0;
		for (int k = 0; k < 4; k++) begin
			mem[64'h1000 + 64'(k * 8)] = rnd64();
			mem[64'h2000 + 64'(k * 8)] = rnd64();
		end
		// Boot load of internal pointers from the initial block
		do_reset(1'b1, 8'h2a);
		tick();
		check(o_sp30, mem[64'h1010]);
		for (int s = 0; s < 3; s++) begin
			do_req(1'b0, prs_sel_t'(4 + s), 64'h0, mem[64'h1008 + 64'(s * 8)]);
		end
		// Internal stack pointers, write then read taken two edges apart
		for (int s = 0; s < 3; s++) begin
			sp[s] = rnd64();
			do_req(1'b1, prs_sel_t'(4 + s), sp[s], 64'h0);
			do_req(1'b0, prs_sel_t'(4 + s), 64'h0, sp[s]);
		end
		// Scalar register 30 reaches the current mode pointer
		i_cur_mode = PRS_MODE_EXEC;
		repeat (2) tick();
		check(o_sp30, sp[0]);
		i_cur_mode = PRS_MODE_USER;
		v = rnd64();
		i_sp30_we = 1'b1;
		i_sp30_wdata = v;
		tick();
		i_sp30_we = 1'b0;
		tick();
		check(o_sp30, v);
		do_req(1'b0, PRS_SEL_USER_SP, 64'h0, v);
		// Page table base register
		do_req(1'b0, PRS_SEL_VIRTUAL_PAGE_TABLE_BASE, 64'h0, PRS_VIRTUAL_PAGE_TABLE_BASE_RST);
		v = rnd64();
		do_req(1'b1, PRS_SEL_VIRTUAL_PAGE_TABLE_BASE, v, 64'h0);
		do_req(1'b0, PRS_SEL_VIRTUAL_PAGE_TABLE_BASE, 64'h0, v);
		// Write then read on consecutive edges, results noted first
		v = rnd64();
		exp_q.push_back(64'h0);
		exp_q.push_back(v);
		i_req = '{1'b1, 1'b1, PRS_SEL_VIRTUAL_PAGE_TABLE_BASE, v};
		tick();
		i_req = '{1'b1, 1'b0, PRS_SEL_VIRTUAL_PAGE_TABLE_BASE, 64'h0};
		tick();
		i_req.valid = 1'b0;
		repeat (2) tick();
		// Identity is read-only
		do_req(1'b0, PRS_SEL_IDENT, 64'h0, 64'h2a);
		do_req(1'b1, PRS_SEL_IDENT, rnd64(), 64'h0);
		do_req(1'b0, PRS_SEL_IDENT, 64'h0, 64'h2a);
		// Every invalidate command, prompt and slow buffer
		for (int it = 0; it < 2; it++) begin
			tlb_lat = it * 2;
			for (int s = 0; s < 4; s++) begin
				v = rnd64();
				if (s == 0) tlb_q.push_back(prs_tlb_t'{1'b1, 1'b1, 1'b1, 1'b1,
					64'h0});
				else tlb_q.push_back(prs_tlb_t'{1'b1, 1'b0, s != 3, s != 2,
					v & ~((64'h1 << PRS_PAGE_BITS) - 64'h1)});
				do_req(1'b1, prs_sel_t'(s), v, 64'h0);
				check(o_xlate_hold, 1'b0);
			end
		end
		// Context swap loads all pointers from the new block
		i_ctx_base = 64'h2000;
		mem_lat = 1;
		do_req(1'b1, PRS_SEL_CTX_SWAP, 64'h2000, 64'h0);
		for (int s = 0; s < 3; s++) begin
			do_req(1'b0, prs_sel_t'(4 + s), 64'h0, mem[64'h2008 + 64'(s * 8)]);
		end
		i_cur_mode = PRS_MODE_KERN;
		repeat (2) tick();
		check(o_sp30, mem[64'h2000]);
		// Second reset: pointers in memory, out-of-range strap
		do_reset(1'b0, 8'hff);
		do_req(1'b0, PRS_SEL_IDENT, 64'h0, 64'(PRS_CPU_COUNT - 8'h01));
		mem_lat = 2;
		for (int s = 0; s < 3; s++) begin
			v = rnd64();
			do_req(1'b1, prs_sel_t'(4 + s), v, 64'h0);
			check(memrd(64'h2008 + 64'(s * 8)), v);
			do_req(1'b0, prs_sel_t'(4 + s), 64'h0, v);
		end
		repeat (4) tick();
		check(exp_q.size(), 0);
		print_verdict();
	end

endmodule
